//--- hw/txc_tx_input_ctrl.sv
// Transmit input stage with transmit clock supervision for all channels.
// ==========================================================
// How it works
// - Transmit inputs are sampled on each falling edge of the channel clock.
// - Single rail bits are AMI coded or zero substituted, B8ZS or HDB3.
// - Clock high over 16 master clocks, master running, enters all-ones state.
// - All-ones pattern is timed by the master clock.
// - Clock low for at least 64 master clocks powers the channel down.
// - Powered-down channel releases its line driver outputs.
// - Receive path runs regardless of transmit clock state.
// - Master clock held high selects plain sliced receive data.
`timescale 1ns/1ps

module txc_tx_input_ctrl
   import txc_pkg::*;
#(
   parameter int N_CH = 8
)(
   input  wire logic            I_CLOCK,          // System clock, 25 MHz
   input  wire logic            I_RST,            // Async reset, high
   input  wire logic            I_MCLK,           // Master clock pin
   input  wire logic [N_CH-1:0] I_TX_LINE_CLK,    // Transmit clock per channel
   input  wire logic [N_CH-1:0] I_TX_SERIAL_IN,   // Single rail NRZ data
   input  wire logic [N_CH-1:0] I_TX_POS_RAIL_IN, // Dual rail positive data
   input  wire logic [N_CH-1:0] I_TX_NEG_RAIL_IN, // Dual rail negative data
   input  wire logic            I_DUAL_RAIL,      // Dual rail mode select
   input  wire logic            I_ZS_CODE_EN,     // Zero substitution enable
   input  wire logic            I_HDB3_SEL,       // HDB3, else B8ZS
   input  wire logic [N_CH-1:0] I_RX_SLICE_POS,   // Sliced receive positive
   input  wire logic [N_CH-1:0] I_RX_SLICE_NEG,   // Sliced receive negative
   input  wire logic [N_CH-1:0] I_RX_REC_POS,     // Recovered receive positive
   input  wire logic [N_CH-1:0] I_RX_REC_NEG,     // Recovered receive negative
   output logic      [N_CH-1:0] O_TX_POS,         // Line positive pulse
   output logic      [N_CH-1:0] O_TX_NEG,         // Line negative pulse
   output logic      [N_CH-1:0] O_TX_OE,          // Line driver enable
   output logic      [N_CH-1:0] O_TX_ALL_ONES_STATE, // Channel in all-ones state
   output logic      [N_CH-1:0] O_TX_POWER_DOWN,  // Channel powered down
   output logic      [N_CH-1:0] O_RX_POS,         // Receive positive out
   output logic      [N_CH-1:0] O_RX_NEG,         // Receive negative out
   output logic                 O_RX_SLICE_ONLY   // Receive in slicing mode
);
   // ==========================================================
   // Synchroniser layout
   localparam int OFS_MCLK = 0;
   localparam int OFS_TCLK = 1;
   localparam int OFS_SER  = OFS_TCLK + N_CH;
   localparam int OFS_POS  = OFS_SER  + N_CH;
   localparam int OFS_NEG  = OFS_POS  + N_CH;
   localparam int OFS_RSP  = OFS_NEG  + N_CH;
   localparam int OFS_RSN  = OFS_RSP  + N_CH;
   localparam int OFS_RRP  = OFS_RSN  + N_CH;
   localparam int OFS_RRN  = OFS_RRP  + N_CH;
   localparam int OFS_CFG  = OFS_RRN  + N_CH;
   localparam int SW       = OFS_CFG  + 3;

   typedef struct packed {
      logic [SW-1:0]                  sync1;
      logic [SW-1:0]                  sync2;
      logic [N_CH-1:0]                tclk_q;
      logic                           mclk_q;
      logic [IDLE_W-1:0]              idle_cnt;
      logic                           mclk_run;
      logic                           slice_only;
      logic [N_CH-1:0][CNT_W-1:0]     hi_cnt;
      logic [N_CH-1:0][CNT_W-1:0]     lo_cnt;
      txc_state_t [N_CH-1:0]          st;
      logic [N_CH-1:0]                tick;
      logic [N_CH-1:0]                bit_in;
      logic [N_CH-1:0]                pos_in;
      logic [N_CH-1:0]                neg_in;
      logic [N_CH-1:0]                all_ones;
      logic [N_CH-1:0]                pdn;
      logic [N_CH-1:0]                oe;
      logic [N_CH-1:0]                rx_pos;
      logic [N_CH-1:0]                rx_neg;
   } ctl_t;

   ctl_t s;
   ctl_t next_s;

   logic [SW-1:0] async_in;
   logic [N_CH-1:0] tclk_s;
   logic mclk_s;
   logic mclk_rise;
   logic dual_s;
   logic zs_s;
   logic hdb3_s;

   assign async_in = {I_HDB3_SEL, I_ZS_CODE_EN, I_DUAL_RAIL,
                      I_RX_REC_NEG, I_RX_REC_POS, I_RX_SLICE_NEG, I_RX_SLICE_POS,
                      I_TX_NEG_RAIL_IN, I_TX_POS_RAIL_IN, I_TX_SERIAL_IN,
                      I_TX_LINE_CLK, I_MCLK};

   assign tclk_s    = s.sync2[OFS_TCLK +: N_CH];
   assign mclk_s    = s.sync2[OFS_MCLK];
   assign mclk_rise = mclk_s & ~s.mclk_q;
   assign dual_s    = s.sync2[OFS_CFG];
   assign zs_s      = s.sync2[OFS_CFG + 1];
   assign hdb3_s    = s.sync2[OFS_CFG + 2];

   always_comb begin
      logic fall;
      logic edge_seen;
      fall      = 1'b0;
      edge_seen = 1'b0;
      next_s    = s;

      // Data and clock share the same two-stage delay, so the falling
      // edge still lines up with the framer's data; setup must exceed
      // one system clock for this to hold.
      next_s.sync1  = async_in;
      next_s.sync2  = s.sync1;
      next_s.tclk_q = tclk_s;
      next_s.mclk_q = mclk_s;

      // ==========================================================
      // Master clock activity
      // Reset leaves the master clock marked idle until its first edge,
      // so supervision cannot enter all-ones before that clock is seen.
      if (mclk_s != s.mclk_q) begin
         next_s.idle_cnt = '0;
         next_s.mclk_run = 1'b1;
      end else if (s.idle_cnt != IDLE_W'(MCLK_STUCK_CYC)) begin
         next_s.idle_cnt = s.idle_cnt + 1'b1;
      end else begin
         next_s.mclk_run = 1'b0;
      end
      // Judged on the next running flag, so the first edge after reset or
      // after a long stall cannot flash slicing mode for one cycle.
      next_s.slice_only = ~next_s.mclk_run & mclk_s;

      // Receive mux never looks at transmit state
      for (int i = 0; i < N_CH; i++) begin
         next_s.rx_pos[i] = s.slice_only ? s.sync2[OFS_RSP + i] : s.sync2[OFS_RRP + i];
         next_s.rx_neg[i] = s.slice_only ? s.sync2[OFS_RSN + i] : s.sync2[OFS_RRN + i];
      end

      // ==========================================================
      // Per-channel supervision and sampling
      for (int i = 0; i < N_CH; i++) begin
         fall      = s.tclk_q[i] & ~tclk_s[i];
         edge_seen = s.tclk_q[i] ^ tclk_s[i];
         next_s.tick[i] = 1'b0;

         if (fall) begin
            next_s.bit_in[i] = s.sync2[OFS_SER + i];
            next_s.pos_in[i] = s.sync2[OFS_POS + i];
            next_s.neg_in[i] = s.sync2[OFS_NEG + i];
         end

         // Counters saturate, and a state once entered is left only on an
         // edge, so a long stall cannot wrap back to normal.
         if (edge_seen) begin
            next_s.hi_cnt[i] = '0;
            next_s.lo_cnt[i] = '0;
            next_s.st[i]     = ST_NORMAL;
         end else if (mclk_rise) begin
            if (tclk_s[i] && s.hi_cnt[i] != CNT_MAX) begin
               next_s.hi_cnt[i] = s.hi_cnt[i] + 1'b1;
            end
            if (!tclk_s[i] && s.lo_cnt[i] != CNT_MAX) begin
               next_s.lo_cnt[i] = s.lo_cnt[i] + 1'b1;
            end
            if (tclk_s[i] && s.mclk_run && s.hi_cnt[i] >= TX_ALL_ONES_STATE_HIGH_MCLK) begin
               next_s.st[i] = ST_ALL_ONES;
            end
            if (!tclk_s[i] && s.lo_cnt[i] + 1'b1 >= PDN_LOW_MCLK) begin
               next_s.st[i] = ST_POWER_DOWN;
            end
         end

         // Ticks follow the registered state, so the deciding master clock
         // edge itself never produces an all-ones bit.
         unique case (s.st[i])
            ST_NORMAL:     next_s.tick[i] = fall;
            ST_ALL_ONES:   next_s.tick[i] = mclk_rise;
            ST_POWER_DOWN: next_s.tick[i] = 1'b0;
            default:       next_s.tick[i] = 1'b0;
         endcase

         next_s.all_ones[i] = (next_s.st[i] == ST_ALL_ONES);
         next_s.pdn[i]      = (next_s.st[i] == ST_POWER_DOWN);
         next_s.oe[i]       = (next_s.st[i] != ST_POWER_DOWN);
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         s    <= '0;
         s.st <= {N_CH{ST_NORMAL}};
         s.oe <= '1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Line encoders
   for (genvar g = 0; g < N_CH; g++) begin : g_enc
      txc_line_encoder u_enc (
         .i_clk      (I_CLOCK),
         .i_rst      (I_RST),
         .i_tick     (s.tick[g]),
         .i_bit      (s.bit_in[g]),
         .i_pos_in   (s.pos_in[g]),
         .i_neg_in   (s.neg_in[g]),
         .i_dual     (dual_s),
         .i_zs_en    (zs_s),
         .i_hdb3     (hdb3_s),
         .i_all_ones (s.all_ones[g]),
         .o_pos      (O_TX_POS[g]),
         .o_neg      (O_TX_NEG[g])
      );
   end

   assign O_TX_OE             = s.oe;
   assign O_TX_ALL_ONES_STATE = s.all_ones;
   assign O_TX_POWER_DOWN     = s.pdn;
   assign O_RX_POS            = s.rx_pos;
   assign O_RX_NEG            = s.rx_neg;
   assign O_RX_SLICE_ONLY     = s.slice_only;
endmodule

//--- hw/txc_line_encoder.sv
// Shared constants and the per-channel transmit line encoder.
`timescale 1ns/1ps

package txc_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int MCLK_STUCK_NS  = 2000;
   localparam int MCLK_STUCK_CYC = (MCLK_STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_W         = $clog2(MCLK_STUCK_CYC + 1);
   // ==========================================================
   // Transmit clock supervision, counted in master clock cycles
   localparam int                CNT_W          = 7;
   localparam logic [CNT_W-1:0]  TX_ALL_ONES_STATE_HIGH_MCLK = 7'h10;
   localparam logic [CNT_W-1:0]  PDN_LOW_MCLK   = 7'h40;
   localparam logic [CNT_W-1:0]  CNT_MAX        = 7'h7F;
   // ==========================================================
   // Line code pipeline
   localparam int PIPE_DEPTH = 8;
   localparam int HDB3_RUN   = 4;
   localparam int B8ZS_RUN   = 8;
   localparam logic LAST_POS_RST = 1'b0;

   typedef enum logic [2:0] {
      ST_NORMAL     = 3'b001,
      ST_ALL_ONES   = 3'b010,
      ST_POWER_DOWN = 3'b100
   } txc_state_t;

   typedef enum logic [1:0] {
      SYM_ZERO = 2'h0,
      SYM_MARK = 2'h1,
      SYM_VIOL = 2'h2
   } txc_sym_t;

   typedef txc_sym_t [PIPE_DEPTH-1:0] txc_pipe_t;
endpackage

module txc_line_encoder
   import txc_pkg::*;
(
   input  wire logic i_clk,      // System clock
   input  wire logic i_rst,      // Async reset, high
   input  wire logic i_tick,     // One bit time
   input  wire logic i_bit,      // Sampled single rail bit
   input  wire logic i_pos_in,   // Sampled positive rail
   input  wire logic i_neg_in,   // Sampled negative rail
   input  wire logic i_dual,     // Dual rail pass-through
   input  wire logic i_zs_en,    // Zero substitution on
   input  wire logic i_hdb3,     // HDB3 else B8ZS
   input  wire logic i_all_ones, // Send all ones
   output logic      o_pos,      // Positive pulse
   output logic      o_neg       // Negative pulse
);
   typedef struct packed {
      txc_pipe_t sym;
      logic      last_pos;
      logic      b_odd;
      logic      pos;
      logic      neg;
   } enc_t;

   enc_t s;
   enc_t next_s;

   // True when the oldest n symbols are all plain zeros
   function automatic logic zero_run(input txc_pipe_t p, input int n);
      logic z;
      z = 1'b1;
      for (int k = 0; k < PIPE_DEPTH; k++) begin
         if (k >= PIPE_DEPTH - n && p[k] != SYM_ZERO) begin
            z = 1'b0;
         end
      end
      return z;
   endfunction

   always_comb begin
      txc_pipe_t w;
      w      = s.sym;
      next_s = s;
      if (i_tick) begin
         if (i_all_ones) begin
            // Plain alternating marks; stale pipeline is dropped
            next_s.pos      = ~s.last_pos;
            next_s.neg      = s.last_pos;
            next_s.last_pos = ~s.last_pos;
            next_s.sym      = '{default: SYM_ZERO};
         end else if (i_dual) begin
            next_s.pos = i_pos_in;
            next_s.neg = i_neg_in;
         end else begin
            if (i_zs_en && i_hdb3 && zero_run(w, HDB3_RUN)) begin
               w[7] = s.b_odd ? SYM_ZERO : SYM_MARK;
               w[4] = SYM_VIOL;
            end else if (i_zs_en && !i_hdb3 && zero_run(w, B8ZS_RUN)) begin
               w = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_VIOL,
                    SYM_MARK, SYM_ZERO, SYM_VIOL, SYM_MARK};
            end
            unique case (w[PIPE_DEPTH-1])
               SYM_ZERO: begin
                  next_s.pos = 1'b0;
                  next_s.neg = 1'b0;
               end
               SYM_MARK: begin
                  next_s.pos      = ~s.last_pos;
                  next_s.neg      = s.last_pos;
                  next_s.last_pos = ~s.last_pos;
                  next_s.b_odd    = ~s.b_odd;
               end
               SYM_VIOL: begin
                  next_s.pos   = s.last_pos;
                  next_s.neg   = ~s.last_pos;
                  next_s.b_odd = 1'b0;
               end
               default: begin
                  next_s.pos = 1'b0;
                  next_s.neg = 1'b0;
               end
            endcase
            next_s.sym = {w[PIPE_DEPTH-2:0], (i_bit ? SYM_MARK : SYM_ZERO)};
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s          <= '0;
         s.last_pos <= LAST_POS_RST;
      end else begin
         s <= next_s;
      end
   end

   assign o_pos = s.pos;
   assign o_neg = s.neg;
endmodule

//--- verification/txc_tx_input_ctrl_props.sv
// Checker for transmit clock supervision and receive path selection.
`timescale 1ns/1ps

module txc_tx_input_ctrl_props
   import txc_pkg::*;
#(
   parameter int N_CH = 8
)(
   input wire logic            I_CLOCK,             // Clock
   input wire logic            I_RST,               // Reset
   input wire logic            I_MCLK,              // Master clock
   input wire logic [N_CH-1:0] I_TX_LINE_CLK,       // Tx clocks
   input wire logic [N_CH-1:0] I_RX_SLICE_POS,      // Sliced rx
   input wire logic [N_CH-1:0] I_RX_REC_NEG,        // Recovered rx
   input wire logic [N_CH-1:0] O_TX_POS,            // Line pos
   input wire logic [N_CH-1:0] O_TX_NEG,            // Line neg
   input wire logic [N_CH-1:0] O_TX_OE,             // Driver enable
   input wire logic [N_CH-1:0] O_TX_ALL_ONES_STATE, // All-ones
   input wire logic [N_CH-1:0] O_TX_POWER_DOWN,     // Power-down
   input wire logic [N_CH-1:0] O_RX_POS,            // Rx pos
   input wire logic [N_CH-1:0] O_RX_NEG,            // Rx neg
   input wire logic            O_RX_SLICE_ONLY      // Slicing mode
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   // ==========================================================
   // Channel 0 supervision
   sequence tclk_rise;
      $rose(I_TX_LINE_CLK[0]);
   endsequence
   sequence tclk_fall;
      $fell(I_TX_LINE_CLK[0]);
   endsequence
   sequence drive_back;
      !O_TX_POWER_DOWN[0] && O_TX_OE[0];
   endsequence
   chk_oe_off_pdn: assert property (O_TX_POWER_DOWN[0] |-> !O_TX_OE[0])
      else $error("driver enabled in power-down");
   chk_aos_tclk_high: assert property ($rose(O_TX_ALL_ONES_STATE[0]) |->
      $past(I_TX_LINE_CLK[0], 3)) else $error("all-ones with clock low");
   chk_pdn_tclk_low: assert property ($rose(O_TX_POWER_DOWN[0]) |->
      !$past(I_TX_LINE_CLK[0], 3)) else $error("power-down with clock high");
   chk_aos_exit: assert property (O_TX_ALL_ONES_STATE[0] ##0 tclk_fall |->
      ##[1:6] !O_TX_ALL_ONES_STATE[0]) else $error("all-ones kept");
   chk_pdn_exit: assert property (O_TX_POWER_DOWN[0] ##0 tclk_rise |->
      ##[1:6] drive_back) else $error("power-down kept");
   // Forty cycles covers one master clock period, so a tick has come
   chk_aos_marks: assert property (O_TX_ALL_ONES_STATE[0] &&
      $past(O_TX_ALL_ONES_STATE[0], 40) |-> O_TX_POS[0] != O_TX_NEG[0])
      else $error("all-ones bit not a mark");
   // ==========================================================
   // Receive selection
   chk_slice_cause: assert property ($rose(O_RX_SLICE_ONLY) |->
      $past(I_MCLK, 3) && $past(I_MCLK, 40)) else $error("slicing without stuck clock");
   chk_rx_sliced: assert property (O_RX_SLICE_ONLY && $past(O_RX_SLICE_ONLY, 4) |->
      O_RX_POS == $past(I_RX_SLICE_POS, 3)) else $error("sliced data wrong");
   chk_rx_recovered: assert property (!O_RX_SLICE_ONLY && !$past(O_RX_SLICE_ONLY, 4)
      && !$past(I_RST, 4) |-> O_RX_NEG == $past(I_RX_REC_NEG, 3))
      else $error("recovered data wrong");
endmodule

bind txc_tx_input_ctrl txc_tx_input_ctrl_props #(.N_CH(N_CH)) chk_u (
   .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_MCLK(I_MCLK), .I_TX_LINE_CLK(I_TX_LINE_CLK),
   .I_RX_SLICE_POS(I_RX_SLICE_POS), .I_RX_REC_NEG(I_RX_REC_NEG), .O_TX_POS(O_TX_POS),
   .O_TX_NEG(O_TX_NEG), .O_TX_OE(O_TX_OE), .O_TX_ALL_ONES_STATE(O_TX_ALL_ONES_STATE),
   .O_TX_POWER_DOWN(O_TX_POWER_DOWN), .O_RX_POS(O_RX_POS), .O_RX_NEG(O_RX_NEG),
   .O_RX_SLICE_ONLY(O_RX_SLICE_ONLY));

//--- verification/txc_framer_model.sv
// Framer model driving transmit clocks and serial data.
`timescale 1ns/1ps

module txc_framer_model #(
   parameter int N_CH = 8
)(
   input  wire logic [N_CH-1:0] i_run,  // Clock toggles
   input  wire logic [N_CH-1:0] i_hold, // Level when stopped
   input  wire logic [N_CH-1:0] i_bits, // Next bit
   output logic      [N_CH-1:0] o_tclk, // Transmit clocks
   output logic      [N_CH-1:0] o_data  // NRZ data
);
   logic ph = 1'b0;
   // Offset keeps link clock edges between system clock edges
   initial begin
      #10;
      forever #160 ph = ~ph;
   end
   // Data moves on the rise so it is steady at the sampling fall
   always @(posedge ph) o_data <= i_bits;
   assign o_tclk = (i_run & {N_CH{ph}}) | (~i_run & i_hold);
endmodule

//--- verification/txc_tx_input_ctrl_bench.sv
// Bench for the transmit input stage: line codes, supervision, receive mux.
`timescale 1ns/1ps

module txc_tx_input_ctrl_bench;
   import txc_pkg::*;
   logic       clk = 0, rst = 1, mck = 0, mrun = 1, mhold = 0, dual = 0, zs = 0, hdb3 = 0;
   logic [7:0] run = 8'hFF, hold = 8'h00, bits = 8'hFF, slice;
   logic [7:0] sp = 8'h5A, sn = 8'hA5, rp = 8'h3C, rn = 8'hC3;
   logic [7:0] tclk, tdat, pos, neg, oe, aos, pdn, rxp, rxn;
   int         fail_count = 0, n_tests = 0;
   logic [7:0] mclk;
   logic       slice_bit;
   always_comb mclk = {7'h0, (mrun ? mck : mhold)};
   always_comb slice = {7'h0, slice_bit};
   always #20 clk = ~clk;
   // Offset keeps master clock edges clear of system clock edges
   initial begin
      #5;
      forever #324 mck = ~mck;
   end

   txc_framer_model fr_u (.i_run(run), .i_hold(hold), .i_bits(bits), .o_tclk(tclk),
      .o_data(tdat));
   txc_tx_input_ctrl dut_u (.I_CLOCK(clk), .I_RST(rst), .I_MCLK(mclk[0]), .I_TX_LINE_CLK(tclk),
      .I_TX_SERIAL_IN(tdat), .I_TX_POS_RAIL_IN(tdat), .I_TX_NEG_RAIL_IN(~tdat),
      .I_DUAL_RAIL(dual), .I_ZS_CODE_EN(zs), .I_HDB3_SEL(hdb3), .I_RX_SLICE_POS(sp),
      .I_RX_SLICE_NEG(sn), .I_RX_REC_POS(rp), .I_RX_REC_NEG(rn), .O_TX_POS(pos),
      .O_TX_NEG(neg), .O_TX_OE(oe), .O_TX_ALL_ONES_STATE(aos), .O_TX_POWER_DOWN(pdn),
      .O_RX_POS(rxp), .O_RX_NEG(rxn), .O_RX_SLICE_ONLY(slice_bit));

   task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wait_bit(input string what, ref logic [7:0] sig, input logic val);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if (sig[0] === val) return;
      end
      check_val(what, {7'h0, val}, sig);
      print_verdict();
   endtask
   // Both levels are polled so each edge is counted exactly once
   task automatic wait_edge(input string what, ref logic [7:0] sig, input logic val);
      wait_bit(what, sig, ~val);
      wait_bit(what, sig, val);
   endtask
   // ==========================================================
   // Sixteen bits after the 8-deep pipeline has flushed
   task automatic line_run(input logic d, z, h, b, input logic [7:0] exp_m, exp_p);
      logic [7:0] m, p;
      logic       last;
      m = 0;
      p = 0;
      @(negedge clk);
      dual = d; zs = z; hdb3 = h; bits = {8{b}};
      for (int i = 0; i < 28; i++) begin
         wait_edge("tclk fall", tclk, 1'b0);
         repeat (6) @(negedge clk);
         if (i >= 12) begin
            m += {7'h0, pos[0] | neg[0]};
            p += {7'h0, pos[0]};
            if (!d && !z && i > 12) check_val("ami alt", {7'h0, ~last}, {7'h0, pos[0]});
            last = pos[0];
         end
      end
      check_val("marks", exp_m, m);
      check_val("positive", exp_p, p);
   endtask
   task automatic test_line_codes();
      line_run(0, 0, 0, 1, 8'h10, 8'h08);
      line_run(0, 1, 0, 0, 8'h08, 8'h04);
      line_run(0, 1, 1, 0, 8'h08, 8'h04);
      line_run(1, 0, 0, 1, 8'h10, 8'h10);
   endtask
   task automatic test_all_ones();
      logic last;
      @(negedge clk);
      dual = 0; zs = 0; hold[0] = 1; run[0] = 0;
      repeat (15) wait_edge("mclk rise", mclk, 1'b1);
      check_val("aos early", 8'h00, aos);
      wait_bit("aos set", aos, 1);
      check_val("aos chans", 8'h01, aos);
      for (int i = 0; i < 6; i++) begin
         wait_edge("mclk fall", mclk, 1'b0);
         if (i > 1) check_val("aos alt", {7'h0, ~last}, {7'h0, pos[0]});
         if (i > 0) check_val("aos mark", 8'h01, {7'h0, pos[0] ^ neg[0]});
         last = pos[0];
      end
      @(negedge clk);
      run[0] = 1;
      wait_bit("aos clear", aos, 0);
   endtask
   task automatic test_power_down();
      @(negedge clk);
      hold[0] = 0; run[0] = 0;
      repeat (60) wait_edge("mclk rise", mclk, 1'b1);
      check_val("pdn early", 8'h00, pdn);
      wait_bit("pdn set", pdn, 1);
      check_val("oe off", 8'hFE, oe);
      check_val("rx in pdn", rp, rxp);
      @(negedge clk);
      run[0] = 1;
      wait_bit("pdn clear", pdn, 0);
      repeat (2) @(negedge clk);
      check_val("oe on", 8'hFF, oe);
   endtask
   task automatic test_receive();
      check_val("slice off", 8'h00, {7'h0, slice[0]});
      mrun = 0;
      mhold = 1;
      wait_bit("slice on", slice, 1);
      repeat (4) @(negedge clk);
      check_val("rx pos", sp, rxp);
      check_val("rx neg", sn, rxn);
      mrun = 1;
      wait_bit("slice off", slice, 0);
      repeat (4) @(negedge clk);
      check_val("rx rec", rn, rxn);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 0;
      test_line_codes();
      test_all_ones();
      test_power_down();
      test_receive();
      print_verdict();
   end
endmodule
